// >>> hdl/fsg_gate.sv
// Command gate of a serial flash: frames opcodes on the serial clock, then decides
// on the system clock which commands pass while busy or suspended.
// Assumes the array engine reports start, completion and failures on clk_in.
//
// How it works
// R1: Program failures set a sticky program fail flag, erase failures a sticky erase fail flag.
// R2: Opcodes 75h and B0h are one and the same suspend command.
// R3: An accepted suspend pauses the running operation for other commands.
// R4: Suspend is opcode only on the serial input, no address or data.
// R5: Host shifts the opcode in over eight clocks, most significant bit first.
// R6: Suspend acts only after chip select rises, never mid-opcode.
// R7: Commands not allowed in the current state are dropped without effect.
// R8: A dropped command leaves the write latch flag unchanged.
// R9: State is busy, else program suspended, else erase suspended, else idle.
// R10: Status, terminate, resets, identity and power-down release pass in every state.
// R11: Array, OTP, lock-status and parameter reads pass when idle or suspended, never when busy.
// R12: Write enable, disable, volatile enable and burst wrap pass when idle or suspended, never when busy.
// R13: Programs pass when idle, or in erase suspend to another 64 kB block.
// R14: Erases, locks, OTP program and status writes never pass when busy or suspended.
// R15: Resume passes only when suspended; a second suspend is refused.
// R16: Power-down release always passes; power-down entries are refused busy or suspended.
// R17: Suspending sets summary and paused flags and clears busy.
// R18: Operations flagged unsuspendable ignore suspend.
// R19: Suspend does not look at the write latch.
// R20: Frames not ending on a byte boundary, or of one to seven bits, do nothing; a frame with no clocks repeats the frame before it.
// R21: Suspension holds until a resume is accepted or reset.
`timescale 1ns/1ps
`default_nettype none

module fsg_gate
    import fsg_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic               spi_clk_in,
    input  wire logic               cs_n_in,
    input  wire logic               si_in,
    input  wire logic               op_start_in,
    input  wire logic [BLOCK_W-1:0] op_block_in,
    input  wire logic               op_is_erase_in,
    input  wire logic               op_nosusp_in,
    input  wire logic               op_done_in,
    input  wire logic               prog_fail_in,
    input  wire logic               erase_fail_in,
    output logic                    busy_flag_out,
    output logic                    program_paused_flag_out,
    output logic                    erase_paused_flag_out,
    output logic                    paused_summary_flag_out,
    output logic                    write_latch_flag_out,
    output logic                    program_fail_flag_out,
    output logic                    erase_fail_flag_out,
    output logic                    cmd_accept_out,
    output logic [7:0]              cmd_code_out,
    output logic [BLOCK_W-1:0]      cmd_block_out,
    output logic                    pause_req_out,
    output logic                    resume_req_out
);

    // Link side: bit phase and byte count, cleared while chip select is high.
    logic               lk_clear;
    logic [2:0]         lk_ph_reg;
    logic [2:0]         lk_ph_next;
    logic [2:0]         lk_by_reg;
    logic [2:0]         lk_by_next;
    logic [31:0]        lk_sh_reg;
    logic [31:0]        lk_sh_next;
    logic [7:0]         lk_op_reg;
    logic [7:0]         lk_op_next;
    logic [BLOCK_W-1:0] lk_blk_reg;
    logic [BLOCK_W-1:0] lk_blk_next;
    logic               lk_opok_reg;
    logic               lk_opok_next;
    logic               lk_adok_reg;
    logic               lk_adok_next;
    logic               lk_align_reg;
    logic               lk_align_next;

    assign lk_clear = rst_in | cs_n_in;

    // Shift on each rising serial clock; opcode after byte one, block after byte four.
    always_comb begin
        lk_ph_next    = lk_ph_reg + 3'h1;
        lk_by_next    = lk_by_reg;
        lk_sh_next    = {lk_sh_reg[30:0], si_in}; // R5
        lk_op_next    = lk_op_reg;
        lk_blk_next   = lk_blk_reg;
        lk_opok_next  = lk_opok_reg;
        lk_adok_next  = lk_adok_reg;
        lk_align_next = (lk_ph_reg == PHASE_LAST); // R20
        if (lk_ph_reg == 3'h0 && lk_by_reg == 3'h0) begin
            lk_opok_next = 1'b0;
            lk_adok_next = 1'b0;
        end
        if (lk_ph_reg == PHASE_LAST) begin
            if (lk_by_reg != BYTES_SAT) begin
                lk_by_next = lk_by_reg + 3'h1;
            end
            if (lk_by_reg == 3'h0) begin
                lk_op_next   = lk_sh_next[7:0];
                lk_opok_next = 1'b1; // R20
            end
            if (lk_by_reg == ADDR_BYTES) begin
                lk_blk_next  = lk_sh_next[BLOCK_MSB:BLOCK_LSB];
                lk_adok_next = 1'b1;
            end
        end
    end

    // Counters restart with every frame; the clock may stand still between frames.
    always_ff @(posedge spi_clk_in or posedge lk_clear) begin
        if (lk_clear) begin
            lk_ph_reg <= 3'h0;
            lk_by_reg <= 3'h0;
        end else begin
            lk_ph_reg <= lk_ph_next;
            lk_by_reg <= lk_by_next;
        end
    end

    // Frame results stay put after chip select rises, so the system side reads them stable.
    always_ff @(posedge spi_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lk_sh_reg    <= 32'h0000_0000;
            lk_op_reg    <= RST_OPCODE;
            lk_blk_reg   <= '0;
            lk_opok_reg  <= RST_FLAG;
            lk_adok_reg  <= RST_FLAG;
            lk_align_reg <= RST_FLAG;
        end else begin
            lk_sh_reg    <= lk_sh_next;
            lk_op_reg    <= lk_op_next;
            lk_blk_reg   <= lk_blk_next;
            lk_opok_reg  <= lk_opok_next;
            lk_adok_reg  <= lk_adok_next;
            lk_align_reg <= lk_align_next;
        end
    end

    // Chip select crosses by two flops; the third only serves the rising-edge detect.
    logic cs_s1_reg;
    logic cs_s2_reg;
    logic cs_s3_reg;
    logic frame_end;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_s1_reg <= RST_CS_N;
            cs_s2_reg <= RST_CS_N;
            cs_s3_reg <= RST_CS_N;
        end else begin
            cs_s1_reg <= cs_n_in;
            cs_s2_reg <= cs_s1_reg;
            cs_s3_reg <= cs_s2_reg;
        end
    end

    assign frame_end = cs_s2_reg & ~cs_s3_reg; // R6

    // System side state.
    logic               busy_reg,  busy_next;
    logic               pp_reg,    pp_next;
    logic               ep_reg,    ep_next;
    logic               sum_reg,   sum_next;
    logic               wl_reg,    wl_next;
    logic               pf_reg,    pf_next;
    logic               ef_reg,    ef_next;
    logic               rune_reg,  rune_next;
    logic               nosus_reg, nosus_next;
    logic [BLOCK_W-1:0] sblk_reg,  sblk_next;
    logic               acc_reg,   acc_next;
    logic [7:0]         code_reg,  code_next;
    logic [BLOCK_W-1:0] blk_reg,   blk_next;
    logic               pause_reg, pause_next;
    logic               res_reg,   res_next;
    logic               valid;
    logic               allow;
    logic               accept;
    fsg_class_t         cls;
    fsg_state_t         st;

    assign valid = frame_end & lk_opok_reg & lk_align_reg; // R20
    assign cls   = fsg_classify(lk_op_reg); // R2
    assign st    = busy_reg ? ST_BUSY : pp_reg ? ST_PSUSP : ep_reg ? ST_ESUSP : ST_IDLE; // R9

    // The acceptance table; idle passes all but suspend and resume.
    always_comb begin
        unique case (st)
            ST_IDLE:  allow = (cls != CLS_SUSPEND) && (cls != CLS_RESUME);
            ST_BUSY:  allow = (cls == CLS_ALWAYS)
                              || (cls == CLS_SUSPEND && !nosus_reg); // R10 R18
            ST_PSUSP: allow = (cls == CLS_ALWAYS) || (cls == CLS_PAUSED_SUMMARY_FLAG)
                              || (cls == CLS_RESUME); // R11 R12 R15
            ST_ESUSP: allow = (cls == CLS_ALWAYS) || (cls == CLS_PAUSED_SUMMARY_FLAG)
                              || (cls == CLS_RESUME)
                              || (cls == CLS_PROG && lk_adok_reg
                                  && lk_blk_reg != sblk_reg); // R13
        endcase
    end

    assign accept = valid & allow; // R7 R14 R16

    // Engine events first, then the accepted command, then failures so a set wins.
    always_comb begin
        busy_next  = busy_reg;
        pp_next    = pp_reg;
        ep_next    = ep_reg;
        sum_next   = sum_reg;
        wl_next    = wl_reg;
        pf_next    = pf_reg;
        ef_next    = ef_reg;
        rune_next  = rune_reg;
        nosus_next = nosus_reg;
        sblk_next  = sblk_reg;
        acc_next   = accept;
        code_next  = accept ? lk_op_reg : code_reg;
        blk_next   = accept ? lk_blk_reg : blk_reg;
        pause_next = 1'b0;
        res_next   = 1'b0;
        if (op_start_in) begin
            busy_next  = 1'b1;
            rune_next  = op_is_erase_in;
            nosus_next = op_nosusp_in;
            wl_next    = 1'b0;
            pf_next    = 1'b0;
            ef_next    = 1'b0;
            if (op_is_erase_in) begin
                sblk_next = op_block_in;
            end
        end
        // A start in the same cycle as a finish keeps busy set, so the set wins.
        if (op_done_in && !op_start_in) begin
            busy_next = 1'b0;
        end
        if (accept) begin
            if (cls == CLS_SUSPEND) begin
                pause_next = 1'b1; // R3 R4 R19
                busy_next  = 1'b0; // R17
                sum_next   = 1'b1;
                pp_next    = pp_reg | ~rune_reg;
                ep_next    = ep_reg | rune_reg;
            end
            if (cls == CLS_RESUME) begin
                res_next   = 1'b1; // R21
                busy_next  = 1'b1;
                nosus_next = 1'b0;
                rune_next  = ~pp_reg;
                pp_next    = 1'b0;
                ep_next    = pp_reg & ep_reg;
                sum_next   = pp_reg & ep_reg;
            end
            if (lk_op_reg == OP_WRITE_EN || lk_op_reg == OP_VOL_WRITE_EN) begin
                wl_next = 1'b1;
            end
            if (lk_op_reg == OP_WRITE_DIS) begin
                wl_next = 1'b0;
            end
        end
        if (prog_fail_in) begin
            pf_next = 1'b1; // R1
        end
        if (erase_fail_in) begin
            ef_next = 1'b1; // R1
        end
    end

    // Only registering here; the write latch is untouched by a refused frame.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_reg  <= RST_FLAG;
            pp_reg    <= RST_FLAG;
            ep_reg    <= RST_FLAG;
            sum_reg   <= RST_FLAG;
            wl_reg    <= RST_FLAG;
            pf_reg    <= RST_FLAG;
            ef_reg    <= RST_FLAG;
            rune_reg  <= RST_FLAG;
            nosus_reg <= RST_FLAG;
            sblk_reg  <= '0;
            acc_reg   <= RST_FLAG;
            code_reg  <= RST_OPCODE;
            blk_reg   <= '0;
            pause_reg <= RST_FLAG;
            res_reg   <= RST_FLAG;
        end else begin
            busy_reg  <= busy_next;
            pp_reg    <= pp_next;
            ep_reg    <= ep_next;
            sum_reg   <= sum_next;
            wl_reg    <= wl_next; // R8
            pf_reg    <= pf_next;
            ef_reg    <= ef_next;
            rune_reg  <= rune_next;
            nosus_reg <= nosus_next;
            sblk_reg  <= sblk_next;
            acc_reg   <= acc_next;
            code_reg  <= code_next;
            blk_reg   <= blk_next;
            pause_reg <= pause_next;
            res_reg   <= res_next;
        end
    end

    // Outputs come straight from the flops above.
    assign busy_flag_out           = busy_reg;
    assign program_paused_flag_out = pp_reg;
    assign erase_paused_flag_out   = ep_reg;
    assign paused_summary_flag_out = sum_reg;
    assign write_latch_flag_out    = wl_reg;
    assign program_fail_flag_out   = pf_reg;
    assign erase_fail_flag_out     = ef_reg;
    assign cmd_accept_out          = acc_reg;
    assign cmd_code_out            = code_reg;
    assign cmd_block_out           = blk_reg;
    assign pause_req_out           = pause_reg;
    assign resume_req_out          = res_reg;

    // Checks on the system clock.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    property p_wait_cs;
        pause_req_out |-> $past(frame_end);
    endproperty
    a_wait_cs: assert property (p_wait_cs) // R6
        else $error("Pause issued without a frame end.");

    property p_flags;
        pause_req_out |-> !busy_flag_out && paused_summary_flag_out
                          && (program_paused_flag_out || erase_paused_flag_out);
    endproperty
    a_flags: assert property (p_flags) // R17
        else $error("Suspend flags wrong after pause.");

    property p_reject;
        frame_end && !allow |=> !cmd_accept_out && !pause_req_out && !resume_req_out;
    endproperty
    a_reject: assert property (p_reject) // R7
        else $error("Refused command had an effect.");

    property p_latch;
        frame_end && !allow && !op_start_in |=> $stable(write_latch_flag_out);
    endproperty
    a_latch: assert property (p_latch) // R8
        else $error("Write latch changed on a refused command.");

    property p_resume;
        valid && cls == CLS_RESUME && busy_flag_out |=> !resume_req_out;
    endproperty
    a_resume: assert property (p_resume) // R15
        else $error("Resume taken while busy.");

    property p_never;
        valid && cls == CLS_NEVER && st != ST_IDLE |=> !cmd_accept_out;
    endproperty
    a_never: assert property (p_never) // R14
        else $error("Forbidden command accepted while busy or suspended.");

    property p_prog;
        valid && cls == CLS_PROG && st != ST_ESUSP && st != ST_IDLE |=> !cmd_accept_out;
    endproperty
    a_prog: assert property (p_prog) // R13
        else $error("Program accepted outside erase suspend.");

    property p_no_latch_needed;
        valid && cls == CLS_SUSPEND && st == ST_BUSY && !nosus_reg
        && !op_start_in && !op_done_in |=> pause_req_out ##1 !busy_flag_out;
    endproperty
    a_no_latch_needed: assert property (p_no_latch_needed) // R19
        else $error("Valid suspend did not pause.");

    property p_hold;
        $fell(paused_summary_flag_out) |-> resume_req_out;
    endproperty
    a_hold: assert property (p_hold) // R21
        else $error("Suspension ended without resume.");

    property p_fail;
        prog_fail_in ##1 !op_start_in |=> program_fail_flag_out;
    endproperty
    a_fail: assert property (p_fail) // R1
        else $error("Program failure not flagged.");

endmodule // fsg_gate

`default_nettype wire

// >>> hdl/fsg_pkg.sv
// Constants, command classes and the opcode classifier for the suspend command gate.
// Assumes opcodes arrive eight bits, most significant bit first, then a 24-bit address.
package fsg_pkg;

    // Bits per opcode or address byte, and bytes of address after the opcode.
    localparam int          BYTE_BITS   = 8;
    localparam logic [2:0]  PHASE_LAST  = 3'h7;
    localparam logic [2:0]  ADDR_BYTES  = 3'h3;
    localparam logic [2:0]  BYTES_SAT   = 3'h4;
    // Position of the 64 kB block number inside the 32-bit frame shift register.
    localparam int          BLOCK_MSB   = 23;
    localparam int          BLOCK_LSB   = 16;
    localparam int          BLOCK_W     = BLOCK_MSB - BLOCK_LSB + 1;
    // Values after reset.
    localparam logic        RST_FLAG    = 1'b0;
    localparam logic        RST_CS_N    = 1'b1;
    localparam logic [7:0]  RST_OPCODE  = 8'h00;

    // Opcodes that change the write latch directly.
    localparam logic [7:0]  OP_WRITE_EN     = 8'h06;
    localparam logic [7:0]  OP_WRITE_DIS    = 8'h04;
    localparam logic [7:0]  OP_VOL_WRITE_EN = 8'h50;

    // How a command is treated while busy or suspended.
    typedef enum logic [2:0] {
        CLS_ALWAYS,
        CLS_PAUSED_SUMMARY_FLAG,
        CLS_PROG,
        CLS_SUSPEND,
        CLS_RESUME,
        CLS_NEVER
    } fsg_class_t;

    // Device state as seen from the three status flags.
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_BUSY,
        ST_PSUSP,
        ST_ESUSP
    } fsg_state_t;

    // Classifies an opcode; anything unknown is refused while busy or suspended.
    function automatic fsg_class_t fsg_classify(input logic [7:0] op);
        unique case (op)
            8'h05, 8'h35, 8'h15, 8'h65, 8'hf0, 8'h66, 8'h99,
            8'h9f, 8'h90, 8'h94, 8'hab:               return CLS_ALWAYS;
            8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7,
            8'h3c, 8'h3d, 8'h4b, 8'h5a, 8'h06, 8'h04,
            8'h50, 8'h77:                             return CLS_PAUSED_SUMMARY_FLAG;
            8'h02, 8'ha2, 8'h32, 8'had, 8'haf:        return CLS_PROG;
            8'h75, 8'hb0:                             return CLS_SUSPEND;
            8'hd0, 8'h7a:                             return CLS_RESUME;
            default:                                  return CLS_NEVER;
        endcase
    endfunction

endpackage

// >>> tb/fsg_host.sv
// Serial host model that frames opcodes and addresses for the command gate.
// Assumes a link clock period of 80 ns and that the caller spaces frames apart.
`timescale 1ns/1ps
`default_nettype none

module fsg_host (
    output logic spi_clk_out,
    output logic cs_n_out,
    output logic si_out
);
    // The link clock stands still and low between frames, as a mode 0 host leaves it.
    initial begin
        spi_clk_out = 1'b0;
        cs_n_out    = 1'b1;
        si_out      = 1'b0;
    end

    // Shifts the top nbits of data out on the single data line; a count off a byte
    // boundary lets the bench provoke a broken frame on purpose.
    task automatic frame(input logic [31:0] data, input int nbits);
        // Offset from the system clock so that no link edge meets a system edge.
        #7;
        cs_n_out = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            si_out = data[31-i];
            #40 spi_clk_out = 1'b1;
            #40 spi_clk_out = 1'b0;
        end
        // The released line shows the inverse level so stale data never looks valid.
        si_out = ~si_out;
        #40 cs_n_out = 1'b1;
    endtask
endmodule // fsg_host

`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the suspend command gate: frames go in through the
// host model, engine events are driven directly, flags and pulses are compared.
// Assumes the gate answers within eight system clocks after chip select rises.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import fsg_pkg::*;

    logic clk_in = 1'b0, rst_in = 1'b1;
    logic op_start = 1'b0, op_is_erase = 1'b0, op_nosusp = 1'b0, op_done = 1'b0;
    logic prog_fail = 1'b0, erase_fail = 1'b0;
    logic [7:0] op_block = 8'h00;
    wire logic spi_clk, cs_n, si, busy, pp, ep, sum, latch, pf, ef, acc, pause, resume;
    wire logic [7:0] code;
    wire logic [7:0] blk_seen;
    wire logic [7:0] flags;
    logic [15:0] acc_cnt = 16'h0000, pause_cnt = 16'h0000, resume_cnt = 16'h0000;
    int fail_count = 0, tests_run = 0, cycles = 0;
    logic [7:0] op_list [0:46] = '{8'h05, 8'h35, 8'h15, 8'h65, 8'hf0, 8'h66, 8'h99,
        8'h9f, 8'h90, 8'h94, 8'hab, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'he7, 8'h3c,
        8'h3d, 8'h4b, 8'h5a, 8'h06, 8'h04, 8'h50, 8'h77, 8'h02, 8'ha2, 8'h32, 8'had,
        8'haf, 8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7, 8'h36, 8'h39, 8'h7e, 8'h98, 8'h9b,
        8'h01, 8'h31, 8'h11, 8'h71, 8'h6f, 8'hb9, 8'h79};

    // Flags packed as busy, program paused, erase paused, summary, latch, fails.
    assign flags = {1'b0, busy, pp, ep, sum, latch, pf, ef};

    // The system clock toggles every 2 ns, a period of 4 ns.
    always #2 clk_in = ~clk_in;

    fsg_host host (.spi_clk_out(spi_clk), .cs_n_out(cs_n), .si_out(si));

    fsg_gate uut (.clk_in(clk_in), .rst_in(rst_in), .spi_clk_in(spi_clk), .cs_n_in(cs_n),
        .si_in(si), .op_start_in(op_start), .op_block_in(op_block),
        .op_is_erase_in(op_is_erase), .op_nosusp_in(op_nosusp), .op_done_in(op_done),
        .prog_fail_in(prog_fail), .erase_fail_in(erase_fail), .busy_flag_out(busy),
        .program_paused_flag_out(pp), .erase_paused_flag_out(ep),
        .paused_summary_flag_out(sum), .write_latch_flag_out(latch),
        .program_fail_flag_out(pf), .erase_fail_flag_out(ef), .cmd_accept_out(acc),
        .cmd_code_out(code), .cmd_block_out(blk_seen), .pause_req_out(pause),
        .resume_req_out(resume));

    // Pulses are counted so that a missed or doubled one shows as a wrong total.
    always @(posedge clk_in) begin
        acc_cnt    <= acc_cnt + {15'h0000, acc};
        pause_cnt  <= pause_cnt + {15'h0000, pause};
        resume_cnt <= resume_cnt + {15'h0000, resume};
    end

    // Cuts a hang short; the whole run needs well under this many cycles.
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            conclude();
        end
    end

    // Prints the totals and the verdict, then ends the run.
    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Compares one seen value with its expectation and reports a difference at once.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Sends one frame and checks whether it passed the gate, and its code if it did.
    task automatic issue(input logic [7:0] op, input logic [7:0] blk, input int nbits,
                         input logic exp_acc);
        logic [15:0] a0;
        a0 = acc_cnt;
        host.frame({op, blk, 16'h0000}, nbits);
        repeat (8) @(posedge clk_in);
        check(8'(acc_cnt - a0), {7'h00, exp_acc}, "accept count");
        if (exp_acc)
            check(code, op, "opcode");
        if (exp_acc && nbits >= 32)
            check(blk_seen, blk, "block");
    endtask

    // Drives one engine event for a single cycle, then lets it settle.
    task automatic engine(input logic st, input logic dn, input logic er, input logic ns,
                          input logic pfl, input logic efl, input logic [7:0] blk);
        @(posedge clk_in);
        op_start    <= st;
        op_done     <= dn;
        op_is_erase <= er;
        op_nosusp   <= ns;
        prog_fail   <= pfl;
        erase_fail  <= efl;
        op_block    <= blk;
        @(posedge clk_in);
        op_start   <= 1'b0;
        op_done    <= 1'b0;
        prog_fail  <= 1'b0;
        erase_fail <= 1'b0;
        repeat (2) @(posedge clk_in);
    endtask

    // Walks the whole opcode table; with prog_ok set, programs carry an address in another block.
    task automatic run_table(input int n_ok, input logic prog_ok);
        logic is_prog;
        for (int i = 0; i < 47; i++) begin
            is_prog = (i >= 25) && (i < 30);
            issue(op_list[i], 8'h06, (is_prog && prog_ok) ? 32 : 8,
                  (i < n_ok) || (is_prog && prog_ok));
        end
    endtask

    // Main sequence: idle, busy, erase suspend, nested program suspend, resumes.
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        check(flags, 8'h00, "flags after reset");
        issue(8'h06, 8'h00, 8, 1'b1);
        check(flags, 8'h04, "latch set when idle");
        engine(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h05);
        check(flags, 8'h40, "erase running");
        run_table(11, 1'b0);
        check(flags, 8'h40, "latch kept on refusal");
        issue(8'h75, 8'h00, 7, 1'b0);
        issue(8'hd0, 8'h00, 8, 1'b0);
        issue(8'h75, 8'h00, 8, 1'b1);
        check(flags, 8'h18, "erase suspended");
        check(pause_cnt[7:0], 8'h01, "pause pulses");
        run_table(25, 1'b1);
        issue(8'hb0, 8'h00, 8, 1'b0);
        issue(8'h02, 8'h05, 32, 1'b0);
        check(flags, 8'h1c, "still erase suspended");
        engine(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h06);
        check(flags, 8'h58, "program in suspend");
        issue(8'hb0, 8'h00, 8, 1'b1);
        check(flags, 8'h38, "both suspended");
        check(pause_cnt[7:0], 8'h02, "pause pulses");
        run_table(25, 1'b0);
        issue(8'hd0, 8'h00, 8, 1'b1);
        check(flags, 8'h5c, "program resumed first");
        check(resume_cnt[7:0], 8'h01, "resume pulses");
        engine(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        check(flags, 8'h1c, "back to erase suspend");
        issue(8'h7a, 8'h00, 8, 1'b1);
        check(flags, 8'h44, "erase resumed");
        check(resume_cnt[7:0], 8'h02, "resume pulses");
        engine(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        engine(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h02);
        issue(8'h75, 8'h00, 8, 1'b0);
        check(flags, 8'h40, "unsuspendable stays busy");
        engine(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
        check(flags, 8'h43, "fail flags");
        engine(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        check(flags, 8'h03, "fail flags sticky");
        conclude();
    end
endmodule // testbench

`default_nettype wire
